// >>> rtl/mcsr_top.sv
`timescale 1ns/10ps
// Function
// R1 - Each 16-bit register is moved as an upper and a lower byte.
// R2 - Writing top config bit resets all like power-on, then clears itself.
// R3 - Bus range bit: zero 16 V, one 32 V; one after reset.
// R4 - Two gain bits pick 40, 80, 160 or 320 mV; default 11.
// R5 - Four bus converter bits set resolution or averaging; default 0011.
// R6 - Four shunt converter bits set resolution or averaging; default 0011.
// R7 - Top bit zero: third bit ignored, low bits give 9-12 bit singles.
// R8 - Top bit one: average 1 to 128 samples, 532 us to 68.10 ms.
// R9 - Three mode bits decode power-down, triggered, off and continuous modes.
// R10 - After reset mode is continuous shunt and bus.
// R11 - Shunt result is read-only, latest conversion, zero after reset.
// R12 - Shunt magnitude position within the word follows the gain.
// R13 - All sign bits carry the same value.
// R14 - Negative shunt values are two's complement, top bit one.
// R15 - 320 mV: one sign bit, full scale 7D00 and 8300.
// R16 - 160 mV: two sign bits, full scale 3E80 and C180.
// R17 - 80 mV: three sign bits, full scale 1F40 and E0C0.
// R18 - 40 mV: four sign bits, full scale 0FA0 and F060.
// R19 - A written value takes effect 4 us after the write ends.
// R20 - Overrange shunt readings clamp at the gain's full-scale code.
// R21 - A new result replaces both bytes of the shunt word at once.
module mcsr_top
	import mcsr_pkg::*;
#(
	parameter int SETTLE_CYC = MCSR_SETTLE_CYC
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic [7:0] PTR,
	input wire logic WR_BYTE,
	input wire logic WR_HIGH,
	input wire logic [7:0] WR_DATA,
	input wire logic WR_DONE,
	input wire logic RD_HIGH,
	output logic [7:0] RD_DATA,
	input wire logic SHUNT_VALID,
	input wire logic signed [17:0] SHUNT_RAW,
	output logic BUS_RANGE_32V,
	output logic [1:0] SHUNT_GAIN_AMP,
	output logic [3:0] BUS_CONV_SETTING,
	output logic [3:0] SHUNT_CONV_SETTING,
	output logic [2:0] OP_SEL,
	output logic SHUNT_ENABLE,
	output logic BUS_ENABLE,
	output logic CONTINUOUS,
	output logic CONV_TRIGGER,
	output logic [3:0] SHUNT_RES_BITS,
	output logic [7:0] SHUNT_AVG_SAMPLES
);
	typedef struct packed {
		logic [15:0] cfg;
		logic [15:0] pend;
		logic [15:0] shunt;
		logic [7:0] hi_hold;
		logic [7:0] rd;
		logic apply_rst;
		logic trig;
		logic sh_en;
		logic bus_en;
		logic cont;
		logic [3:0] res;
		logic [7:0] avg;
	} mcsr_state_t;

	mcsr_state_t st_reg;
	mcsr_state_t st_next;
	logic settle_done;
	logic [15:0] staged;
	mcsr_cfg_if cfg_bus ();

	// Converter setting to resolution and sample count
	function automatic logic [11:0] mcsr_conv(input logic [3:0] c);
		logic [3:0] bits;
		logic [7:0] n;
		bits = 4'hc;
		n = 8'h01;
		if (!c[3]) begin
			bits = 4'h9 + {2'b00, c[1:0]}; // R7
		end else begin
			n = 8'h01 << c[2:0]; // R8
		end
		return {bits, n};
	endfunction : mcsr_conv

	mcsr_settle #(.CYCLES(SETTLE_CYC)) u_settle (
		.clk(CLK_SYS),
		.rst(RST),
		.start(WR_DONE && PTR == MCSR_PTR_CONFIG),
		.done(settle_done)
	);

	assign cfg_bus.gain = st_reg.cfg[MCSR_GAIN_LSB +: 2];
	assign cfg_bus.raw = SHUNT_RAW;
	mcsr_shunt_enc u_enc (
		.port(cfg_bus)
	);

	// Pending word gathered byte by byte until the write ends
	always_comb begin
		staged = st_reg.pend;
		if (WR_BYTE && PTR == MCSR_PTR_CONFIG) begin
			if (WR_HIGH) begin
				staged[15:8] = WR_DATA; // R1
			end else begin
				staged[7:0] = WR_DATA; // R1
			end
		end
	end

	// Next state of configuration, result and derived controls
	always_comb begin
		mcsr_mode_t m;
		logic [11:0] sc;
		m = MCSR_M_BOTH_CONT;
		sc = 12'h000;
		st_next = st_reg;
		st_next.trig = 1'b0;
		st_next.apply_rst = 1'b0;
		st_next.pend = staged;
		// Value lands only after the settle delay expires
		if (settle_done) begin
			if (st_reg.pend[MCSR_RST_BIT]) begin
				st_next.apply_rst = 1'b1; // R2
			end else begin
				st_next.cfg = st_reg.pend & MCSR_CONFIG_MASK; // R19 R3 R4 R5 R6
				st_next.trig = ~st_reg.pend[MCSR_MODE_LSB + 2]
					& (st_reg.pend[MCSR_MODE_LSB +: 2] != 2'b00); // R9
			end
		end
		// Whole word taken in one edge so bytes never mix results
		if (SHUNT_VALID && st_reg.sh_en) begin
			st_next.shunt = cfg_bus.code; // R11 R21
		end
		// Latch low byte when high byte is read for a coherent pair
		if (RD_HIGH) begin
			st_next.hi_hold = (PTR == MCSR_PTR_SHUNT) ? st_reg.shunt[7:0] : st_reg.cfg[7:0];
			st_next.rd = (PTR == MCSR_PTR_SHUNT) ? st_reg.shunt[15:8] : st_reg.cfg[15:8];
			if (PTR != MCSR_PTR_SHUNT && PTR != MCSR_PTR_CONFIG) begin
				st_next.rd = 8'h00;
			end
		end else begin
			st_next.rd = st_reg.hi_hold; // R1
		end
		m = mcsr_mode_t'(st_next.cfg[MCSR_MODE_LSB +: 3]);
		case (m)
			MCSR_M_SH_TRIG, MCSR_M_SH_CONT: begin
				st_next.sh_en = 1'b1; // R9
				st_next.bus_en = 1'b0;
			end
			MCSR_M_BUS_TRIG, MCSR_M_BUS_CONT: begin
				st_next.sh_en = 1'b0;
				st_next.bus_en = 1'b1;
			end
			MCSR_M_BOTH_TRIG, MCSR_M_BOTH_CONT: begin
				st_next.sh_en = 1'b1;
				st_next.bus_en = 1'b1;
			end
			default: begin
				st_next.sh_en = 1'b0;
				st_next.bus_en = 1'b0;
			end
		endcase
		st_next.cont = st_next.cfg[MCSR_MODE_LSB + 2] && st_next.cfg[MCSR_MODE_LSB +: 2] != 2'b00;
		sc = mcsr_conv(st_next.cfg[MCSR_SCONV_LSB +: 4]); // R6
		st_next.res = sc[11:8];
		st_next.avg = sc[7:0];
	end

	// Soft reset reuses the power-on path; bit 15 never stores so it self-clears
	always_ff @(posedge CLK_SYS) begin
		if (RST || st_reg.apply_rst) begin
			st_reg <= '0; // R2
			st_reg.cfg <= MCSR_CONFIG_RESET; // R3 R4 R5 R6 R10
			st_reg.pend <= MCSR_CONFIG_RESET;
			st_reg.shunt <= MCSR_SHUNT_RESET; // R11
			st_reg.sh_en <= 1'b1;
			st_reg.bus_en <= 1'b1;
			st_reg.cont <= 1'b1;
			st_reg.res <= 4'hc;
			st_reg.avg <= 8'h01;
		end else begin
			st_reg <= st_next;
		end
	end

	assign RD_DATA = st_reg.rd;
	assign BUS_RANGE_32V = st_reg.cfg[MCSR_BUS_RANGE_BIT]; // R3
	assign SHUNT_GAIN_AMP = st_reg.cfg[MCSR_GAIN_LSB +: 2]; // R4
	assign BUS_CONV_SETTING = st_reg.cfg[MCSR_BCONV_LSB +: 4]; // R5
	assign SHUNT_CONV_SETTING = st_reg.cfg[MCSR_SCONV_LSB +: 4];
	assign OP_SEL = st_reg.cfg[MCSR_MODE_LSB +: 3];
	assign SHUNT_ENABLE = st_reg.sh_en;
	assign BUS_ENABLE = st_reg.bus_en;
	assign CONTINUOUS = st_reg.cont;
	assign CONV_TRIGGER = st_reg.trig;
	assign SHUNT_RES_BITS = st_reg.res;
	assign SHUNT_AVG_SAMPLES = st_reg.avg;
endmodule : mcsr_top

// >>> shared/mcsr_pkg.sv
package mcsr_pkg;
	// Register pointer values
	localparam logic [7:0] MCSR_PTR_CONFIG = 8'h00;
	localparam logic [7:0] MCSR_PTR_SHUNT = 8'h01;
	// Configuration field positions
	localparam int MCSR_RST_BIT = 15;
	localparam int MCSR_BUS_RANGE_BIT = 13;
	localparam int MCSR_GAIN_LSB = 11;
	localparam int MCSR_BCONV_LSB = 7;
	localparam int MCSR_SCONV_LSB = 3;
	localparam int MCSR_MODE_LSB = 0;
	// Writable bits of the configuration word; bit 14 is reserved and reads zero
	localparam logic [15:0] MCSR_CONFIG_MASK = 16'h3fff;
	localparam logic [15:0] MCSR_CONFIG_RESET = 16'h399f;
	localparam logic [15:0] MCSR_SHUNT_RESET = 16'h0000;
	// Full-scale magnitudes, 10 uV steps
	localparam logic [15:0] MCSR_FS_320 = 16'h7d00;
	localparam logic [15:0] MCSR_FS_160 = 16'h3e80;
	localparam logic [15:0] MCSR_FS_80 = 16'h1f40;
	localparam logic [15:0] MCSR_FS_40 = 16'h0fa0;
	// Write settling time
	localparam int MCSR_CLK_MHZ = 200;
	localparam int MCSR_SETTLE_US = 4;
	localparam int MCSR_SETTLE_CYC = MCSR_SETTLE_US * MCSR_CLK_MHZ;
	typedef enum logic [2:0] {
		MCSR_M_PDOWN, MCSR_M_SH_TRIG, MCSR_M_BUS_TRIG, MCSR_M_BOTH_TRIG,
		MCSR_M_OFF, MCSR_M_SH_CONT, MCSR_M_BUS_CONT, MCSR_M_BOTH_CONT
	} mcsr_mode_t;
endpackage : mcsr_pkg

// >>> shared/mcsr_cfg_if.sv
`timescale 1ns/10ps
interface mcsr_cfg_if;
	logic [1:0] gain;
	logic signed [17:0] raw;
	logic [15:0] code;
	modport enc (input gain, input raw, output code);
	modport top (output gain, output raw, input code);
endinterface : mcsr_cfg_if

// >>> rtl/mcsr_shunt_enc.sv
`timescale 1ns/10ps
module mcsr_shunt_enc
	import mcsr_pkg::*;
(
	mcsr_cfg_if.enc port
);
	logic [15:0] fs;
	logic signed [17:0] pos;
	logic signed [17:0] neg;
	// Full scale picked from gain; sign copies fill the unused top bits
	always_comb begin
		case (port.gain)
			2'b00: fs = MCSR_FS_40; // R18
			2'b01: fs = MCSR_FS_80; // R17
			2'b10: fs = MCSR_FS_160; // R16
			default: fs = MCSR_FS_320; // R15
		endcase
		pos = signed'({2'b00, fs});
		neg = -pos;
		// Clamp instead of wrapping so far overrange keeps its sign
		if (port.raw > pos) begin
			port.code = pos[15:0]; // R20
		end else if (port.raw < neg) begin
			port.code = neg[15:0]; // R20 R14
		end else begin
			port.code = port.raw[15:0]; // R12 R13 R14
		end
	end
endmodule : mcsr_shunt_enc

// >>> rtl/mcsr_settle.sv
`timescale 1ns/10ps
module mcsr_settle
	import mcsr_pkg::*;
#(
	parameter int CYCLES = MCSR_SETTLE_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	output logic done
);
	typedef struct packed {
		logic [15:0] cnt;
		logic busy;
		logic done;
	} mcsr_st_t;
	mcsr_st_t s_reg;
	mcsr_st_t s_next;
	// Counts the delay between a write and its effect
	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		if (start) begin
			s_next.busy = 1'b1;
			s_next.cnt = 16'(CYCLES - 1);
		end else if (s_reg.busy) begin
			if (s_reg.cnt == 16'h0000) begin
				s_next.busy = 1'b0;
				s_next.done = 1'b1;
			end else begin
				s_next.cnt = s_reg.cnt - 16'h0001;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
	assign done = s_reg.done;
endmodule : mcsr_settle

// >>> sim/mcsr_top_sva.sv
`timescale 1ns/10ps
module mcsr_top_chk
	import mcsr_pkg::*;
#(
	parameter int SETTLE_CYC = MCSR_SETTLE_CYC
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic WR_DONE,
	input wire logic [7:0] RD_DATA,
	input wire logic BUS_RANGE_32V,
	input wire logic [1:0] SHUNT_GAIN_AMP,
	input wire logic [3:0] BUS_CONV_SETTING,
	input wire logic [3:0] SHUNT_CONV_SETTING,
	input wire logic [2:0] OP_SEL,
	input wire logic SHUNT_ENABLE,
	input wire logic BUS_ENABLE,
	input wire logic CONTINUOUS,
	input wire logic CONV_TRIGGER,
	input wire logic [3:0] SHUNT_RES_BITS,
	input wire logic [7:0] SHUNT_AVG_SAMPLES
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	rst_fields_a: assert property ($fell(RST) |-> BUS_RANGE_32V && SHUNT_GAIN_AMP == 2'h3
		&& OP_SEL == 3'h7) else $error("reset fields wrong");
	rst_conv_a: assert property ($fell(RST) |-> BUS_CONV_SETTING == 4'h3
		&& SHUNT_CONV_SETTING == 4'h3) else $error("reset converter fields wrong");
	rst_read_a: assert property ($fell(RST) |-> RD_DATA == 8'h00)
		else $error("read byte not zero after reset");
	shunt_dec_a: assert property (SHUNT_ENABLE == OP_SEL[0]) else $error("shunt enable decode");
	bus_dec_a: assert property (BUS_ENABLE == OP_SEL[1]) else $error("bus enable decode");
	cont_dec_a: assert property (CONTINUOUS == (OP_SEL[2] && OP_SEL[1:0] != 2'b00))
		else $error("continuous decode");
	trig_mode_a: assert property (CONV_TRIGGER |-> OP_SEL inside {3'h1, 3'h2, 3'h3})
		else $error("trigger outside triggered mode");
	avg_res_a: assert property (SHUNT_CONV_SETTING[3] && $stable(SHUNT_CONV_SETTING)
		|-> SHUNT_RES_BITS == 4'hc) else $error("averaging resolution wrong");
	single_res_a: assert property (!SHUNT_CONV_SETTING[3] && $stable(SHUNT_CONV_SETTING)
		|-> SHUNT_AVG_SAMPLES == 8'h01 && SHUNT_RES_BITS == 4'h9 + SHUNT_CONV_SETTING[1:0])
		else $error("single conversion setting wrong");
	settle_hold_a: assert property (WR_DONE |=> $stable(OP_SEL) [*3])
		else $error("config applied before settling");
endmodule : mcsr_top_chk
bind mcsr_top mcsr_top_chk #(.SETTLE_CYC(SETTLE_CYC)) u_mcsr_top_chk (.*);

// >>> sim/mcsr_host_model.sv
`timescale 1ns/10ps
module mcsr_host_model (
	input wire logic clk,
	input wire logic [7:0] rd_data,
	output logic [7:0] ptr,
	output logic wr_byte,
	output logic wr_high,
	output logic [7:0] wr_data,
	output logic wr_done,
	output logic rd_high
);
	// Idle at time zero
	initial begin
		{ptr, wr_byte, wr_high, wr_data, wr_done, rd_high} = '0;
	end
	// Upper then lower byte, then stop; data line scrambled once released
	task automatic wr(input logic [7:0] p, input logic [15:0] d);
		@(negedge clk) {ptr, wr_byte, wr_high, wr_data} = {p, 2'b11, d[15:8]};
		@(negedge clk) {wr_high, wr_data} = {1'b0, d[7:0]};
		@(negedge clk) {wr_byte, wr_done, wr_data} = {2'b01, ~d[7:0]};
		@(negedge clk) wr_done = 1'b0;
		repeat (12) @(negedge clk);
	endtask : wr
	// High byte the cycle after the request, low byte snapshot next
	task automatic rd(input logic [7:0] p, output logic [15:0] d);
		@(negedge clk) {ptr, rd_high} = {p, 1'b1};
		@(negedge clk) {rd_high, d[15:8]} = {1'b0, rd_data};
		@(negedge clk) d[7:0] = rd_data;
	endtask : rd
endmodule : mcsr_host_model

// >>> sim/monitor_config_and_shunt_result_bench.sv
`timescale 1ns/10ps
module monitor_config_and_shunt_result_bench;
	import mcsr_pkg::*;
	logic CLK_SYS = 1'b0;
	logic RST = 1'b1;
	logic SHUNT_VALID = 1'b0;
	logic signed [17:0] SHUNT_RAW = '0;
	logic [7:0] PTR, WR_DATA, RD_DATA, SHUNT_AVG_SAMPLES;
	logic WR_BYTE, WR_HIGH, WR_DONE, RD_HIGH, BUS_RANGE_32V, SHUNT_ENABLE, BUS_ENABLE;
	logic CONTINUOUS, CONV_TRIGGER;
	logic [1:0] SHUNT_GAIN_AMP;
	logic [3:0] BUS_CONV_SETTING, SHUNT_CONV_SETTING, SHUNT_RES_BITS;
	logic [2:0] OP_SEL;
	logic [15:0] got;
	int err_total = 0;
	int checked = 0;
	int trig_seen = 0;
	always #2.5 CLK_SYS = ~CLK_SYS;
	// Trigger lasts one cycle, so tally it at every falling edge
	always @(negedge CLK_SYS) begin
		if (CONV_TRIGGER === 1'b1) begin
			trig_seen++;
		end
	end
	// Short settle count keeps the run brief
	mcsr_top #(.SETTLE_CYC(4)) u_mcsr_top (.CLK_SYS, .RST, .PTR, .WR_BYTE, .WR_HIGH, .WR_DATA,
		.WR_DONE, .RD_HIGH, .RD_DATA, .SHUNT_VALID, .SHUNT_RAW, .BUS_RANGE_32V, .SHUNT_GAIN_AMP,
		.BUS_CONV_SETTING, .SHUNT_CONV_SETTING, .OP_SEL, .SHUNT_ENABLE, .BUS_ENABLE, .CONTINUOUS,
		.CONV_TRIGGER, .SHUNT_RES_BITS, .SHUNT_AVG_SAMPLES);
	mcsr_host_model u_mcsr_host_model (.clk(CLK_SYS), .rd_data(RD_DATA), .ptr(PTR),
		.wr_byte(WR_BYTE), .wr_high(WR_HIGH), .wr_data(WR_DATA), .wr_done(WR_DONE),
		.rd_high(RD_HIGH));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wrap_up;
		if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	// Raw sample, then the scrambled value while not valid
	task automatic feed(input logic signed [17:0] r, input logic [15:0] e);
		@(negedge CLK_SYS) {SHUNT_VALID, SHUNT_RAW} = {1'b1, r};
		@(negedge CLK_SYS) {SHUNT_VALID, SHUNT_RAW} = {1'b0, ~r};
		u_mcsr_host_model.rd(8'h01, got);
		chk(got, e);
	endtask : feed
	task automatic t_reset;
		u_mcsr_host_model.rd(8'h00, got);
		chk(got, 16'h399f);
		u_mcsr_host_model.rd(8'h01, got);
		chk(got, 16'h0000);
		u_mcsr_host_model.rd(8'h07, got);
		chk({8'h00, got[15:8]}, 16'h0000);
	endtask : t_reset
	// Every gain, both overrange ends, minus one and an in-range value
	task automatic t_shunt;
		logic [15:0] fs [4] = '{16'h0fa0, 16'h1f40, 16'h3e80, 16'h7d00};
		for (int g = 0; g < 4; g++) begin
			u_mcsr_host_model.wr(8'h00, 16'h219f | (16'(g) << 11));
			chk({14'h0, SHUNT_GAIN_AMP}, 16'(g));
			feed(18'sd40000, fs[g]);
			feed(-18'sd40000, -fs[g]);
			feed(-18'sd1, 16'hffff);
			feed(18'sd3999, 16'h0f9f);
		end
	endtask : t_shunt
	// Samples offered with the shunt side off must leave the result alone
	task automatic t_modes;
		int t0;
		for (int m = 0; m < 8; m++) begin
			t0 = trig_seen;
			u_mcsr_host_model.wr(8'h00, 16'h3998 | 16'(m));
			chk({SHUNT_ENABLE, BUS_ENABLE, OP_SEL}, {m[0], m[1], m[2:0]});
			chk({15'h0000, CONTINUOUS}, 16'(m >= 5));
			chk(16'(trig_seen - t0), 16'(m inside {[1:3]}));
			if (!m[0]) begin
				feed(18'sd7, 16'h0f9f);
			end
		end
	endtask : t_modes
	// Reserved bit, single setting, averaging, then self-clearing reset
	task automatic t_soft;
		u_mcsr_host_model.wr(8'h00, 16'h5fa7);
		u_mcsr_host_model.rd(8'h00, got);
		chk(got, 16'h1fa7);
		chk({11'h000, BUS_RANGE_32V, BUS_CONV_SETTING}, 16'h000f);
		chk({SHUNT_AVG_SAMPLES, SHUNT_RES_BITS}, 12'h019);
		u_mcsr_host_model.wr(8'h00, 16'h3fff);
		chk({SHUNT_AVG_SAMPLES, SHUNT_RES_BITS}, 12'h80c);
		u_mcsr_host_model.wr(8'h00, 16'h8123);
		u_mcsr_host_model.rd(8'h00, got);
		chk(got, 16'h399f);
		chk({SHUNT_AVG_SAMPLES, SHUNT_RES_BITS}, 12'h01c);
		u_mcsr_host_model.rd(8'h01, got);
		chk(got, 16'h0000);
	endtask : t_soft
	initial begin
		repeat (8) @(negedge CLK_SYS);
		RST = 1'b0;
		t_reset();
		t_shunt();
		t_modes();
		t_soft();
		wrap_up();
	end
	// Hang guard, well past the expected run
	initial begin
		#50000;
		err_total++;
		wrap_up();
	end
endmodule : monitor_config_and_shunt_result_bench
